// >>> rtl/rpc_pkg.sv
// Package with constants and types of the reference positioning control.
package rpc_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int CORR_STEP_NS = 10000;
    localparam int MS_NS = 1000000;
    localparam int CORR_STEP_CYC = CORR_STEP_NS / CLK_PERIOD_NS;
    localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
    // ****************************************************************
    // Register indices and fields
    // ****************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIST = 8'h01;
    localparam logic [7:0] REG_CORR = 8'h02;
    localparam logic [7:0] REG_WAIT = 8'h03;
    localparam logic [7:0] REG_DECEL = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h05;
    localparam logic [7:0] REG_REVS = 8'h06;
    localparam int MODE_LSB = 0;
    localparam int EDGE_LSB = 8;
    localparam int ACT_LSB = 16;
    localparam int STOPD_LSB = 20;
    localparam int LOAD_LSB = 16;
    localparam int POLE_LSB = 16;
    // ****************************************************************
    // Codes
    // ****************************************************************
    localparam logic [3:0] MODE_REF = 4'h1;
    localparam logic [4:0] EDGE_FALL = 5'h01;
    localparam logic [4:0] EDGE_RISE = 5'h0b;
    localparam logic [4:0] EDGE_BOTH = 5'h15;
    localparam logic [3:0] STOP_HOLD = 4'h2;
    localparam logic [71:0] DIST_SCALE = 72'h2710;
    localparam logic [71:0] STOP_NUM = 72'hc350;
    typedef enum logic [2:0] {
        ACT_END = 3'h0, ACT_WAIT_SAME = 3'h1, ACT_WAIT_REV = 3'h2,
        ACT_OFF = 3'h3, ACT_TIME_SAME = 3'h4, ACT_TIME_REV = 3'h5
    } rpc_act_t;
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01, ST_ARMED = 8'h02, ST_DELAY = 8'h04, ST_TRAVEL = 8'h08,
        ST_DECEL = 8'h10, ST_WAIT_EDGE = 8'h20, ST_WAIT_TIME = 8'h40, ST_STOPPED = 8'h80
    } rpc_state_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } rpc_bus_req_t;
    typedef struct packed {
        logic freeze;
        logic hold_speed;
        logic decel;
        logic hold;
        logic stage_off;
        logic run;
        logic dir_cw;
    } rpc_ramp_cmd_t;
endpackage : rpc_pkg

// >>> rtl/rpc_top.sv
// Reference positioning control for a motor drive.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
// Overview of operation
// R1 - Positioning works only while the mode setting is 1; 0 disables it.
// R2 - Start edge code: 1 falling, 11 rising, 21 either edge.
// R3 - Positive signed signal correction advances the reference event, 0.01 ms steps.
// R4 - Negative signal correction delays processing of the reference event.
// R5 - Zero signal correction applies no compensation.
// R6 - Positive load correction lengthens deceleration and travel.
// R7 - Negative load correction brakes sooner, shortening the distance.
// R8 - Zero load correction, the reset value, leaves positioning unchanged.
// R9 - Zero distance stops at once; nonzero distance approached at set deceleration.
// R10 - Distance independent of speed; slow speeds are held before decelerating.
// R11 - An event during a ramp freezes the ramp and holds that speed.
// R12 - Action 0 stops; units digit hold keeps hold, else switch off.
// R13 - Action 1 waits for next edge, then restarts in same direction.
// R14 - Action 2 holds until next edge, then restarts reversed.
// R15 - Action 3 stops and switches the output stage off.
// R16 - Action 4 waits the waiting time, then restarts in same direction.
// R17 - Action 5 waits the waiting time, then restarts reversed.
// R18 - Waiting time 0 to 3600000 ms, default 0, used by timed actions.
// R19 - Action 0 ignores the waiting time.
// R20 - Actual revolutions since the reference event are readable.
// R21 - Decelerate when corrected remaining distance equals stopping distance.
module rpc_top #(
    parameter int MS_CYC = rpc_pkg::MS_CYC,
    parameter int CORR_CYC = rpc_pkg::CORR_STEP_CYC
) (
    input wire logic ref_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset.
    input wire rpc_pkg::rpc_bus_req_t bus_req, // Register access request.
    output logic [31:0] bus_rdata, // Read data, one cycle after read.
    input wire logic reference_input, // Reference sensor pin.
    input wire logic [15:0] speed, // Actual frequency, 0.01 Hz units.
    input wire logic speed_dir_cw, // Present direction of rotation.
    input wire logic pos_step, // One pulse per milli-revolution.
    output rpc_pkg::rpc_ramp_cmd_t ramp_cmd // Commands to the ramp generator.
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [3:0] mode_ff;
    logic [4:0] edge_ff;
    logic [2:0] act_ff;
    logic [3:0] stopd_ff;
    logic [29:0] dist_ff;
    logic signed [15:0] corr_ff;
    logic signed [15:0] load_ff;
    logic [21:0] wait_ff;
    logic [15:0] decel_ff;
    logic [3:0] pole_ff;
    logic [31:0] rdata_ff;
    logic [29:0] trav_ff;
    rpc_pkg::rpc_state_t st_ff;
    rpc_pkg::rpc_state_t nxt_st;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= 4'h0;
            edge_ff <= rpc_pkg::EDGE_FALL;
            act_ff <= 3'h0;
            stopd_ff <= 4'h0;
            dist_ff <= 30'h0;
            corr_ff <= 16'sh0;
            load_ff <= 16'sh0; // R8
            wait_ff <= 22'h0; // R18
            decel_ff <= 16'h1f4;
            pole_ff <= 4'h2;
        end else if (bus_req.wr) begin
            unique case (bus_req.addr)
                rpc_pkg::REG_CTRL: begin
                    mode_ff <= bus_req.wdata[rpc_pkg::MODE_LSB +: 4];
                    edge_ff <= bus_req.wdata[rpc_pkg::EDGE_LSB +: 5];
                    act_ff <= bus_req.wdata[rpc_pkg::ACT_LSB +: 3];
                    stopd_ff <= bus_req.wdata[rpc_pkg::STOPD_LSB +: 4];
                end
                rpc_pkg::REG_DIST: dist_ff <= bus_req.wdata[29:0];
                rpc_pkg::REG_CORR: begin
                    corr_ff <= bus_req.wdata[15:0];
                    load_ff <= bus_req.wdata[rpc_pkg::LOAD_LSB +: 16];
                end
                rpc_pkg::REG_WAIT: wait_ff <= bus_req.wdata[21:0];
                rpc_pkg::REG_DECEL: begin
                    decel_ff <= bus_req.wdata[15:0];
                    pole_ff <= bus_req.wdata[rpc_pkg::POLE_LSB +: 4];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 32'h0;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                rpc_pkg::REG_CTRL: rdata_ff <= {8'h0, stopd_ff, 1'b0, act_ff, 3'h0, edge_ff,
                    4'h0, mode_ff};
                rpc_pkg::REG_DIST: rdata_ff <= {2'h0, dist_ff};
                rpc_pkg::REG_CORR: rdata_ff <= {load_ff, corr_ff};
                rpc_pkg::REG_WAIT: rdata_ff <= {10'h0, wait_ff};
                rpc_pkg::REG_DECEL: rdata_ff <= {12'h0, pole_ff, decel_ff};
                rpc_pkg::REG_STATUS: rdata_ff <= {23'h0, ramp_cmd.dir_cw, st_ff};
                rpc_pkg::REG_REVS: rdata_ff <= {2'h0, trav_ff}; // R20
                default: rdata_ff <= 32'h0;
            endcase
        end else begin
            rdata_ff <= 32'h0;
        end
    end
    assign bus_rdata = rdata_ff;

    // ****************************************************************
    // Reference input synchroniser and edge selection
    // ****************************************************************
    logic sync1_ff, sync2_ff, sync3_ff, lvl_ff;
    logic rise, fall, ref_ev;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= reference_input;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // The level follows the pin only once two stages agree, which filters glitches.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_ff <= 1'b0;
        end else if (sync2_ff == sync3_ff) begin
            lvl_ff <= sync3_ff;
        end
    end

    assign rise = (sync2_ff == sync3_ff) && sync3_ff && !lvl_ff;
    assign fall = (sync2_ff == sync3_ff) && !sync3_ff && lvl_ff;
    always_comb begin
        unique case (edge_ff)
            rpc_pkg::EDGE_FALL: ref_ev = fall; // R2
            rpc_pkg::EDGE_RISE: ref_ev = rise; // R2
            rpc_pkg::EDGE_BOTH: ref_ev = rise | fall; // R2
            default: ref_ev = 1'b0;
        endcase
    end

    // ****************************************************************
    // Stopping distance comparison
    // ****************************************************************
    logic signed [71:0] rem, tc_pos, w_val, lhs, rhs;
    logic decel_now;

    always_comb begin
        rem = $signed({42'h0, dist_ff}) + 72'(load_ff) - $signed({42'h0, trav_ff}); // R6 R7
        tc_pos = (corr_ff > 16'sh0) ? 72'(corr_ff) : 72'sh0; // R3
        w_val = rem * $signed({68'h0, pole_ff}) * $signed(rpc_pkg::DIST_SCALE)
            - $signed({56'h0, speed}) * tc_pos; // R3
        lhs = w_val * $signed({56'h0, decel_ff});
        rhs = $signed(rpc_pkg::STOP_NUM) * $signed({56'h0, speed}) * $signed({56'h0, speed});
        decel_now = (lhs <= rhs); // R21
    end

    // ****************************************************************
    // Counters
    // ****************************************************************
    logic [31:0] dly_ff;
    logic [31:0] pre_ff;
    logic [21:0] ms_ff;
    logic dly_done, wait_done, enter_wait;

    assign dly_done = (dly_ff == 32'h0);
    assign wait_done = (ms_ff == 22'h0);
    assign enter_wait = (st_ff == rpc_pkg::ST_DECEL) && (speed == 16'h0)
        && (act_ff == rpc_pkg::ACT_TIME_SAME || act_ff == rpc_pkg::ACT_TIME_REV);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dly_ff <= 32'h0;
        end else if (st_ff == rpc_pkg::ST_ARMED && corr_ff < 16'sh0) begin
            dly_ff <= 32'(-32'(corr_ff)) * 32'(CORR_CYC); // R4
        end else if (!dly_done) begin
            dly_ff <= dly_ff - 32'h1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_ff <= 32'h0;
            ms_ff <= 22'h0;
        end else if (enter_wait) begin
            pre_ff <= 32'(MS_CYC - 1); // R16 R17
            ms_ff <= wait_ff; // R18
        end else if (st_ff == rpc_pkg::ST_WAIT_TIME && !wait_done) begin
            if (pre_ff == 32'h0) begin
                pre_ff <= 32'(MS_CYC - 1);
                ms_ff <= ms_ff - 22'h1;
            end else begin
                pre_ff <= pre_ff - 32'h1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trav_ff <= 30'h0;
        end else if (st_ff == rpc_pkg::ST_ARMED && ref_ev) begin
            trav_ff <= 30'h0;
        end else if ((st_ff == rpc_pkg::ST_TRAVEL || st_ff == rpc_pkg::ST_DECEL) && pos_step) begin
            trav_ff <= trav_ff + 30'h1; // R20
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    logic start_go;
    assign start_go = (dist_ff == 30'h0) ? 1'b1 : 1'b0;

    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            rpc_pkg::ST_IDLE: if (mode_ff == rpc_pkg::MODE_REF) nxt_st = rpc_pkg::ST_ARMED;
            rpc_pkg::ST_ARMED: begin
                if (ref_ev) begin
                    if (corr_ff < 16'sh0) begin
                        nxt_st = rpc_pkg::ST_DELAY; // R4
                    end else if (start_go) begin
                        nxt_st = rpc_pkg::ST_DECEL; // R5 R9
                    end else begin
                        nxt_st = rpc_pkg::ST_TRAVEL; // R5
                    end
                end
            end
            rpc_pkg::ST_DELAY: begin
                if (dly_done) nxt_st = start_go ? rpc_pkg::ST_DECEL : rpc_pkg::ST_TRAVEL;
            end
            rpc_pkg::ST_TRAVEL: if (decel_now) nxt_st = rpc_pkg::ST_DECEL; // R10 R21
            rpc_pkg::ST_DECEL: begin
                if (speed == 16'h0) begin
                    unique case (act_ff)
                        rpc_pkg::ACT_WAIT_SAME, rpc_pkg::ACT_WAIT_REV:
                            nxt_st = rpc_pkg::ST_WAIT_EDGE; // R13 R14
                        rpc_pkg::ACT_TIME_SAME, rpc_pkg::ACT_TIME_REV:
                            nxt_st = rpc_pkg::ST_WAIT_TIME; // R16 R17
                        default: nxt_st = rpc_pkg::ST_STOPPED; // R12 R15 R19
                    endcase
                end
            end
            rpc_pkg::ST_WAIT_EDGE: if (ref_ev) nxt_st = rpc_pkg::ST_ARMED; // R13 R14
            rpc_pkg::ST_WAIT_TIME: if (wait_done) nxt_st = rpc_pkg::ST_ARMED; // R16 R17
            rpc_pkg::ST_STOPPED: ;
            default: nxt_st = rpc_pkg::ST_IDLE;
        endcase
        if (mode_ff != rpc_pkg::MODE_REF) nxt_st = rpc_pkg::ST_IDLE; // R1
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= rpc_pkg::ST_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************************************
    // Ramp generator commands
    // ****************************************************************
    logic restart, rev_req, stop_hold;
    assign restart = (st_ff == rpc_pkg::ST_WAIT_EDGE && ref_ev)
        || (st_ff == rpc_pkg::ST_WAIT_TIME && wait_done);
    assign rev_req = (act_ff == rpc_pkg::ACT_WAIT_REV) || (act_ff == rpc_pkg::ACT_TIME_REV);
    assign stop_hold = (stopd_ff == rpc_pkg::STOP_HOLD);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ramp_cmd <= '0;
        end else begin
            ramp_cmd.freeze <= (st_ff == rpc_pkg::ST_DELAY) || (st_ff == rpc_pkg::ST_TRAVEL); // R11
            ramp_cmd.hold_speed <= (st_ff == rpc_pkg::ST_TRAVEL); // R10
            ramp_cmd.decel <= (st_ff == rpc_pkg::ST_DECEL); // R9
            ramp_cmd.hold <= (st_ff == rpc_pkg::ST_WAIT_EDGE) || (st_ff == rpc_pkg::ST_WAIT_TIME)
                || (st_ff == rpc_pkg::ST_STOPPED && act_ff == rpc_pkg::ACT_END && stop_hold); // R12
            ramp_cmd.stage_off <= (st_ff == rpc_pkg::ST_STOPPED)
                && (act_ff == rpc_pkg::ACT_OFF || !stop_hold); // R12 R15
            ramp_cmd.run <= restart; // R13 R16
            if (st_ff == rpc_pkg::ST_ARMED && ref_ev) begin
                ramp_cmd.dir_cw <= speed_dir_cw;
            end else if (restart && rev_req) begin
                ramp_cmd.dir_cw <= !ramp_cmd.dir_cw; // R14 R17
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_disabled;
        mode_ff != rpc_pkg::MODE_REF |=> st_ff == rpc_pkg::ST_IDLE;
    endproperty
    a_disabled: assert property (p_disabled) else $error("Not idle while disabled."); // R1

    property p_edge_start;
        st_ff == rpc_pkg::ST_ARMED && ref_ev && mode_ff == rpc_pkg::MODE_REF
            |=> st_ff != rpc_pkg::ST_ARMED;
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("Edge did not start move."); // R2

    property p_neg_delay;
        st_ff == rpc_pkg::ST_ARMED && ref_ev && corr_ff < 16'sh0 && mode_ff == rpc_pkg::MODE_REF
            && mode_ff == $past(mode_ff) ##1 mode_ff == rpc_pkg::MODE_REF [*8]
            |-> $past(st_ff, 7) == rpc_pkg::ST_DELAY;
    endproperty
    a_neg_delay: assert property (p_neg_delay) else $error("Negative correction not delayed."); // R4

    property p_zero_corr;
        st_ff == rpc_pkg::ST_ARMED && ref_ev && corr_ff == 16'sh0 |=> st_ff != rpc_pkg::ST_DELAY;
    endproperty
    a_zero_corr: assert property (p_zero_corr) else $error("Zero correction delayed."); // R5

    property p_dist_zero;
        st_ff == rpc_pkg::ST_ARMED && ref_ev && corr_ff >= 16'sh0 && dist_ff == 30'h0
            && mode_ff == rpc_pkg::MODE_REF |=> st_ff == rpc_pkg::ST_DECEL ##1 ramp_cmd.decel;
    endproperty
    a_dist_zero: assert property (p_dist_zero) else $error("Zero distance not stopped."); // R9

    property p_freeze;
        st_ff == rpc_pkg::ST_TRAVEL |=> ramp_cmd.freeze && ramp_cmd.hold_speed;
    endproperty
    a_freeze: assert property (p_freeze) else $error("Ramp not frozen in travel."); // R11

    property p_end_hold;
        st_ff == rpc_pkg::ST_STOPPED && act_ff == rpc_pkg::ACT_END
            |=> ramp_cmd.hold == $past(stop_hold) && ramp_cmd.stage_off == !$past(stop_hold);
    endproperty
    a_end_hold: assert property (p_end_hold) else $error("End action wrong."); // R12

    property p_off;
        st_ff == rpc_pkg::ST_STOPPED && act_ff == rpc_pkg::ACT_OFF |=> ramp_cmd.stage_off;
    endproperty
    a_off: assert property (p_off) else $error("Stage not switched off."); // R15

    property p_reverse;
        st_ff == rpc_pkg::ST_WAIT_EDGE && ref_ev && act_ff == rpc_pkg::ACT_WAIT_REV
            |=> ramp_cmd.run && ramp_cmd.dir_cw != $past(ramp_cmd.dir_cw);
    endproperty
    a_reverse: assert property (p_reverse) else $error("No reversed restart."); // R14

    property p_revs;
        st_ff == rpc_pkg::ST_TRAVEL && pos_step |=> trav_ff == $past(trav_ff) + 30'h1;
    endproperty
    a_revs: assert property (p_revs) else $error("Revolutions not counted."); // R20

    property p_same_dir;
        st_ff == rpc_pkg::ST_WAIT_EDGE && ref_ev && act_ff == rpc_pkg::ACT_WAIT_SAME
            |=> ramp_cmd.run && ramp_cmd.dir_cw == $past(ramp_cmd.dir_cw);
    endproperty
    a_same_dir: assert property (p_same_dir) else $error("No same-direction restart."); // R13

    property p_timed_restart;
        st_ff == rpc_pkg::ST_WAIT_TIME && wait_done && mode_ff == rpc_pkg::MODE_REF
            |=> st_ff == rpc_pkg::ST_ARMED && ramp_cmd.run;
    endproperty
    a_timed_restart: assert property (p_timed_restart) else $error("No timed restart."); // R16 R17

    property p_end_no_wait;
        st_ff == rpc_pkg::ST_DECEL && speed == 16'h0 && act_ff == rpc_pkg::ACT_END
            && mode_ff == rpc_pkg::MODE_REF |=> st_ff == rpc_pkg::ST_STOPPED;
    endproperty
    a_end_no_wait: assert property (p_end_no_wait) else $error("End action waited."); // R19

    c_stopped: cover property (st_ff == rpc_pkg::ST_DECEL ##1 st_ff == rpc_pkg::ST_STOPPED);
    c_timed: cover property (st_ff == rpc_pkg::ST_WAIT_TIME ##1 ramp_cmd.run);
    c_edge_restart: cover property (st_ff == rpc_pkg::ST_WAIT_EDGE ##1 ramp_cmd.run);
endmodule : rpc_top

// >>> verification/rpc_motor_model.sv
// Behavioural ramp generator and encoder that face the positioning block.
`timescale 1ns/1ns
module rpc_motor_model (
    input wire logic ref_clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire rpc_pkg::rpc_ramp_cmd_t ramp_cmd, // Ramp commands.
    input wire logic load, // Start turning at cruise speed.
    input wire logic [15:0] cruise, // Running speed.
    input wire logic dir_set, // Direction taken on load.
    output logic [15:0] speed, // Actual frequency.
    output logic speed_dir_cw, // Direction of rotation.
    output logic pos_step, // Milli-revolution pulse.
    output logic [31:0] steps // Pulses since load.
);
    logic [3:0] ph_ff;
    logic mov;
    // Pulses come only during a positioning, one in sixteen cycles, so counts stay exact.
    assign mov = (ramp_cmd.freeze || ramp_cmd.decel) && speed != 16'h0 && ph_ff == 4'h0;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_ff <= 4'h0;
            pos_step <= 1'b0;
            steps <= 32'h0;
        end else begin
            ph_ff <= ph_ff + 4'h1;
            pos_step <= mov;
            steps <= load ? 32'h0 : steps + {31'h0, mov};
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            speed <= 16'h0;
            speed_dir_cw <= 1'b0;
        end else if (load || ramp_cmd.run) begin
            speed <= cruise;
            speed_dir_cw <= load ? dir_set : ramp_cmd.dir_cw;
        end else if (ramp_cmd.stage_off) begin
            speed <= 16'h0;
        end else if (ramp_cmd.decel && speed != 16'h0 && ph_ff[1:0] == 2'h0) begin
            speed <= speed - 16'h1;
        end
    end
endmodule : rpc_motor_model

// >>> verification/rpc_top_tb.sv
// Self-checking bench of the reference positioning control.
`timescale 1ns/1ns
module rpc_top_tb;
    localparam int MSC = 50;
    localparam int CRC = 20;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    rpc_pkg::rpc_bus_req_t bus_req = '0;
    logic [31:0] bus_rdata;
    logic reference_input = 1'b0;
    logic [15:0] speed;
    logic speed_dir_cw;
    logic pos_step;
    rpc_pkg::rpc_ramp_cmd_t ramp_cmd;
    logic load = 1'b0;
    logic [31:0] steps;
    logic [31:0] dec_at = '0;
    logic dec_seen = 1'b0;
    logic run_dir = 1'b0;
    logic [31:0] v;
    int fails = 0;
    int num_checks = 0;
    int runs = 0;
    int ec[3] = '{1, 11, 21};
    int ld[5] = '{0, 20, -20, 0, 0};
    int cr[5] = '{0, 0, 0, 1000, -5};
    int ac;
    int r0;
    int n;
    initial forever #5 ref_clk = ~ref_clk;
    rpc_top #(.MS_CYC(MSC), .CORR_CYC(CRC)) i_rpc_top (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .reference_input(reference_input),
        .speed(speed), .speed_dir_cw(speed_dir_cw), .pos_step(pos_step), .ramp_cmd(ramp_cmd));
    rpc_motor_model i_rpc_motor_model (.ref_clk(ref_clk), .rst_n(rst_n), .ramp_cmd(ramp_cmd),
        .load(load), .cruise(16'h64), .dir_set(1'b1), .speed(speed),
        .speed_dir_cw(speed_dir_cw), .pos_step(pos_step), .steps(steps));
    always @(posedge ref_clk) begin
        if (ramp_cmd.run) begin
            runs++;
            run_dir = ramp_cmd.dir_cw;
        end
        if (ramp_cmd.decel && !dec_seen) begin
            dec_seen = 1'b1;
            dec_at = steps;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 v = bus_rdata;
        @(posedge ref_clk);
        if (m != 32'h0) chk(v & m, e);
    endtask : rdchk
    task automatic wst(input logic [7:0] s);
        for (int i = 0; i < 4000; i++) begin
            rdchk(rpc_pkg::REG_STATUS, 32'h0, 32'h0);
            if (v[7:0] === s) break;
        end
        chk({24'h0, v[7:0]}, {24'h0, s});
    endtask : wst
    task automatic edg(input logic b);
        reference_input <= b;
        repeat (6) @(posedge ref_clk);
    endtask : edg
    task automatic arm(input logic [31:0] c, input logic [31:0] d, input logic [31:0] k);
        wr(rpc_pkg::REG_CTRL, 32'h0);
        edg(1'b0);
        wr(rpc_pkg::REG_DIST, d);
        wr(rpc_pkg::REG_CORR, k);
        wr(rpc_pkg::REG_WAIT, 32'h2);
        load <= 1'b1;
        @(posedge ref_clk);
        load <= 1'b0;
        dec_seen = 1'b0;
        wr(rpc_pkg::REG_CTRL, c);
        wst(rpc_pkg::ST_ARMED);
    endtask : arm
    // First travelled count at which braking at 5 Hz/s from 1 Hz with two pole pairs ends on target.
    function automatic int dpt(input int d, input int k);
        longint s = 100;
        for (int t = 0; t < d; t++) begin
            if ((longint'(20000) * (d - t) - s * k) * 500 <= 50000 * s * s) return t;
        end
        return d;
    endfunction : dpt
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    // The tests need about 20000 cycles; the watchdog allows five times that.
    initial begin
        #1000000;
        fails++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rdchk(rpc_pkg::REG_CTRL, 32'h100, 32'hffffffff);
        rdchk(rpc_pkg::REG_DIST, 32'h0, 32'hffffffff);
        rdchk(rpc_pkg::REG_CORR, 32'h0, 32'hffffffff);
        rdchk(rpc_pkg::REG_WAIT, 32'h0, 32'hffffffff);
        rdchk(rpc_pkg::REG_DECEL, 32'h201f4, 32'hffffffff);
        wr(rpc_pkg::REG_REVS, 32'h55);
        rdchk(rpc_pkg::REG_REVS, 32'h0, 32'h3fffffff);
        wr(8'h20, 32'h1);
        rdchk(8'h20, 32'h0, 32'hffffffff);
        edg(1'b1);
        edg(1'b0);
        rdchk(rpc_pkg::REG_STATUS, rpc_pkg::ST_IDLE, 32'hff);
        $display("test reset and mode off done");
        for (int e = 0; e < 3; e++) begin
            arm(32'h30001 | (ec[e] << 8), 32'h0, 32'h0);
            edg(1'b1);
            if (e == 0) begin
                rdchk(rpc_pkg::REG_STATUS, rpc_pkg::ST_ARMED, 32'hff);
                edg(1'b0);
            end
            wst(rpc_pkg::ST_STOPPED);
            chk({31'h0, ramp_cmd.stage_off}, 32'h1);
        end
        $display("test edge codes done");
        for (int a = 0; a < 7; a++) begin
            ac = (a == 6) ? 0 : a;
            arm(((a == 0) ? 32'h200000 : 32'h0) | (ac << 16) | 32'h1501, 32'h0, 32'h0);
            edg(1'b1);
            rdchk(rpc_pkg::REG_STATUS, rpc_pkg::ST_DECEL, 32'hff);
            r0 = runs;
            if (ac == 1 || ac == 2) begin
                wst(rpc_pkg::ST_WAIT_EDGE);
                chk({31'h0, ramp_cmd.hold}, 32'h1);
                edg(1'b0);
            end else if (ac >= 4) begin
                wst(rpc_pkg::ST_WAIT_TIME);
                // The run pulse is read while it stands, so the count does not race the tally.
                for (n = 0; !ramp_cmd.run && n < 1000; n++) @(posedge ref_clk);
                chk({31'h0, n >= 2 * MSC - 12 && n <= 2 * MSC}, 32'h1);
                @(posedge ref_clk);
            end else begin
                wst(rpc_pkg::ST_STOPPED);
                chk({30'h0, ramp_cmd.hold, ramp_cmd.stage_off}, (a == 0) ? 32'h2 : 32'h1);
            end
            if (ac != 0 && ac != 3) begin
                chk(runs - r0, 32'h1);
                chk({31'h0, run_dir}, {31'h0, ac == 1 || ac == 4});
            end
        end
        $display("test follow-on actions done");
        for (int j = 0; j < 5; j++) begin
            arm(32'h200b01, 32'd200, {ld[j][15:0], cr[j][15:0]});
            edg(1'b1);
            rdchk(rpc_pkg::REG_STATUS, (cr[j] < 0) ? rpc_pkg::ST_DELAY : rpc_pkg::ST_TRAVEL,
                32'hff);
            wst(rpc_pkg::ST_TRAVEL);
            chk({30'h0, ramp_cmd.freeze, ramp_cmd.hold_speed}, 32'h3);
            wst(rpc_pkg::ST_STOPPED);
            if (cr[j] >= 0) begin
                chk(dec_at, 32'(dpt(200 + ld[j], cr[j])));
                rdchk(rpc_pkg::REG_REVS, steps, 32'h3fffffff);
            end
        end
        $display("test distance and corrections done");
        summarize();
    end
endmodule : rpc_top_tb
